// File: inc/frtc_cfg.svh
// constants of the free-running timer counter
`ifndef FRTC_CFG_SVH
`define FRTC_CFG_SVH
// ==========================================================
// register byte offsets
`define FRTC_OFF_CNT_HI 6'h00
`define FRTC_OFF_CNT_LO 6'h04
`define FRTC_OFF_ALT_HI 6'h08
`define FRTC_OFF_ALT_LO 6'h0C
`define FRTC_OFF_STATUS 6'h10
`define FRTC_OFF_CTRL1 6'h14
`define FRTC_OFF_CTRL2 6'h18
`define FRTC_OFF_IRQ_STAT 6'h1C
`define FRTC_OFF_IRQ_MASK 6'h20
// ==========================================================
// field positions
`define FRTC_OVF_BIT 0
`define FRTC_IRQEN_BIT 0
`define FRTC_CSEL_LSB 0
`define FRTC_CSEL_MSB 1
`define FRTC_EDGE_BIT 2
`define FRTC_IRQ_OVF_BIT 0
// ==========================================================
// reset and fixed values
`define FRTC_CNT_RESET 16'hFFFC
`define FRTC_CNT_MAX 16'hFFFF
`define FRTC_CNT_ONE 16'h0001
`define FRTC_PSC_ONE 3'h1
`define FRTC_PSC_DIV4 3'h3
`define FRTC_PSC_DIV8 3'h7
`define FRTC_RD_ZERO 32'h0000_0000
`endif

// File: inc/frtc_pkg.sv
// types shared by the free-running timer counter
package frtc_pkg;
  // ========================================================
  // clock source, in field encoding order
  typedef enum logic [1:0] {
    FRTC_DIV2,
    FRTC_DIV4,
    FRTC_DIV8,
    FRTC_EXT
  } frtc_clk_src_t;
  // ========================================================
  // timer_control_two contents
  typedef struct packed {
    logic ext_edge_select;
    frtc_clk_src_t clock_select_field;
  } frtc_ctrl2_t;
  // ========================================================
  // one bus access as seen by the decoder
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] data;
  } frtc_acc_t;
endpackage

// File: rtl/frtc_top.sv
// free-running 16-bit timer counter with avalon-mm register slave
`include "frtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module frtc_top
  import frtc_pkg::*;
#(
  parameter bit EXT_PIN_BONDED = 1'b1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_clock_pin,
  input wire logic halt_mode,
  input wire logic global_irq_mask,
  output logic irq
);
  // ========================================================
  // reset release
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ========================================================
  // address decode
  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a == o);
  endfunction

  frtc_acc_t acc;
  logic wait_reg;
  logic [31:0] rdata_reg;
  assign acc.rd = avs_read & wait_reg;
  assign acc.wr = avs_write & wait_reg;
  assign acc.addr = avs_address;
  assign acc.data = avs_writedata[7:0];

  logic wr_b0;
  assign wr_b0 = acc.wr & avs_byteenable[0];

  logic [1:0] hit_hi;
  logic [1:0] hit_lo;
  logic hit_st, hit_c1, hit_c2, hit_is, hit_im;
  assign hit_hi[0] = hit(acc.addr, `FRTC_OFF_CNT_HI);
  assign hit_hi[1] = hit(acc.addr, `FRTC_OFF_ALT_HI);
  assign hit_lo[0] = hit(acc.addr, `FRTC_OFF_CNT_LO);
  assign hit_lo[1] = hit(acc.addr, `FRTC_OFF_ALT_LO);
  assign hit_st = hit(acc.addr, `FRTC_OFF_STATUS);
  assign hit_c1 = hit(acc.addr, `FRTC_OFF_CTRL1);
  assign hit_c2 = hit(acc.addr, `FRTC_OFF_CTRL2);
  assign hit_is = hit(acc.addr, `FRTC_OFF_IRQ_STAT);
  assign hit_im = hit(acc.addr, `FRTC_OFF_IRQ_MASK);

  // ========================================================
  // control registers
  logic irq_en_reg;
  frtc_ctrl2_t ctrl2_reg;
  logic irq_mask_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= 1'b0;
      ctrl2_reg <= '0;
      irq_mask_reg <= 1'b0;
    end else begin
      if (wr_b0 && hit_c1) begin
        irq_en_reg <= acc.data[`FRTC_IRQEN_BIT];
      end
      if (wr_b0 && hit_c2) begin
        ctrl2_reg <= frtc_ctrl2_t'(acc.data[`FRTC_EDGE_BIT:0]);
      end
      if (wr_b0 && hit_im) begin
        irq_mask_reg <= acc.data[`FRTC_IRQ_OVF_BIT];
      end
    end
  end

  // ========================================================
  // tick generation
  // wait mode has no input here: the counter simply never sees it
  logic ext_in, ext_prev_reg, ext_edge;
  logic [2:0] psc_reg;
  logic [2:0] psc_next;
  logic tick;
  assign ext_in = EXT_PIN_BONDED ? ext_clock_pin : 1'b1;
  // pin treated as synchronous; rate limit is the source's job
  assign ext_edge = ctrl2_reg.ext_edge_select ?
                    (ext_in & ~ext_prev_reg) :
                    (~ext_in & ext_prev_reg);
  assign psc_next = halt_mode ? psc_reg : psc_reg + `FRTC_PSC_ONE;
  always_comb begin
    tick = 1'b0;
    case (ctrl2_reg.clock_select_field)
      FRTC_DIV2: tick = psc_reg[0];
      FRTC_DIV4: tick = (psc_reg[1:0] == `FRTC_PSC_DIV4);
      FRTC_DIV8: tick = (psc_reg == `FRTC_PSC_DIV8);
      FRTC_EXT: tick = ext_edge;
      default: tick = 1'b0;
    endcase
    if (halt_mode) begin
      tick = 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      psc_reg <= 3'h0;
      ext_prev_reg <= 1'b1;
    end else begin
      psc_reg <= psc_next;
      ext_prev_reg <= ext_in;
    end
  end

  // ========================================================
  // counter, single clock edge for every update
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic reload, ovf_evt;
  assign reload = wr_b0 & (hit_lo[0] | hit_lo[1]);
  assign ovf_evt = tick & ~reload & (cnt_reg == `FRTC_CNT_MAX);
  assign cnt_next = reload ? `FRTC_CNT_RESET :
                    tick ? cnt_reg + `FRTC_CNT_ONE : cnt_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= `FRTC_CNT_RESET;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ========================================================
  // buffered 16-bit read, one latch per view
  logic [1:0] lock_reg;
  logic [7:0] lo_buf_reg [2];
  logic [7:0] lo_view [2];
  genvar v;
  generate
    for (v = 0; v < 2; v++) begin : g_view
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          lock_reg[v] <= 1'b0;
          lo_buf_reg[v] <= 8'h00;
        end else if (acc.rd && hit_lo[v]) begin
          lock_reg[v] <= 1'b0;
        end else if (acc.rd && hit_hi[v] && !lock_reg[v]) begin
          lock_reg[v] <= 1'b1;
          lo_buf_reg[v] <= cnt_reg[7:0];
        end
      end
      assign lo_view[v] = lock_reg[v] ? lo_buf_reg[v] : cnt_reg[7:0];
    end
  endgenerate

  // ========================================================
  // overflow flag with two-step clear
  logic flag_reg, armed_reg;
  logic main_lo_acc;
  // alternate low byte is deliberately not part of this term
  assign main_lo_acc = (acc.rd | acc.wr) & hit_lo[0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      if (ovf_evt) begin
        flag_reg <= 1'b1;
      end else if (armed_reg && main_lo_acc) begin
        flag_reg <= 1'b0;
      end
      if (main_lo_acc) begin
        armed_reg <= 1'b0;
      end else if (acc.rd && hit_st && flag_reg) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // ========================================================
  // interrupt: sticky status, write one to clear
  logic istat_reg;
  logic irq_reg;
  logic istat_clr;
  assign istat_clr = wr_b0 & hit_is & acc.data[`FRTC_IRQ_OVF_BIT];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      istat_reg <= ovf_evt | (istat_reg & ~istat_clr);
      // stays pending until enable, mask register and cpu mask allow it
      irq_reg <= istat_reg & irq_mask_reg & irq_en_reg & ~global_irq_mask;
    end
  end
  assign irq = irq_reg;

  // ========================================================
  // read mux and bus handshake
  logic [31:0] rd_mux;
  assign rd_mux =
    hit_hi[0] ? {24'h00_0000, cnt_reg[15:8]} :
    hit_hi[1] ? {24'h00_0000, cnt_reg[15:8]} :
    hit_lo[0] ? {24'h00_0000, lo_view[0]} :
    hit_lo[1] ? {24'h00_0000, lo_view[1]} :
    hit_st ? {31'h0000_0000, flag_reg} :
    hit_c1 ? {31'h0000_0000, irq_en_reg} :
    hit_c2 ? {29'h0000_0000, ctrl2_reg} :
    hit_is ? {31'h0000_0000, istat_reg} :
    hit_im ? {31'h0000_0000, irq_mask_reg} : `FRTC_RD_ZERO;
  // fixed two-cycle answer keeps the slave free of stall logic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= `FRTC_RD_ZERO;
    end else begin
      wait_reg <= ~(acc.rd | acc.wr);
      if (acc.rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
endmodule
`default_nettype wire

// File: verif/frtc_checker.sv
// port checks for the timer counter
`timescale 1ns/1ps
`default_nettype none
module frtc_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic global_irq_mask,
  input wire logic irq
);
  // ====
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire logic rd_take = avs_read && avs_waitrequest;
  a_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after accept");
  a_wait_single: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("ready held too long");
  a_idle_busy: assert property (
    !(avs_read || avs_write) |=> avs_waitrequest)
    else $error("ready without request");
  a_read_width: assert property (
    rd_take |=> avs_readdata[31:8] == 24'h00_0000)
    else $error("bits above byte not zero");
  a_unmapped_zero: assert property (
    rd_take && avs_address == 6'h24 |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_status_width: assert property (
    rd_take && avs_address == 6'h10 |=> avs_readdata[31:1] == 31'h0)
    else $error("status spare bits set");
  a_data_hold: assert property (
    !rd_take |=> $stable(avs_readdata))
    else $error("read data moved without read");
  a_irq_masked: assert property (
    global_irq_mask |=> !irq)
    else $error("irq while globally masked");
endmodule
bind frtc_top frtc_checker chk_u (.ref_clk, .resetn, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .global_irq_mask, .irq);
`default_nettype wire

// File: verif/frtc_ext_src.sv
// external count clock source model
`timescale 1ns/1ps
`default_nettype none
module frtc_ext_src (
  input wire logic ref_clk,
  input wire logic run,
  output logic ext_clock_pin = 1'b0
);
  logic [1:0] ph_reg = 2'h0;
  // four clocks per level, so active edges stay eight apart
  always @(posedge ref_clk) begin
    if (run) begin
      ph_reg <= ph_reg + 2'h1;
      if (ph_reg == 2'h3) ext_clock_pin <= ~ext_clock_pin;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the timer counter
`include "frtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import frtc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rdat;
  logic avs_waitrequest, irq, ext_clock_pin;
  logic halt_mode = 1'b1;
  logic global_irq_mask = 1'b0;
  logic ext_run = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  always #4 ref_clk = ~ref_clk;
  frtc_top dut_u (.ref_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .ext_clock_pin, .halt_mode, .global_irq_mask, .irq);
  frtc_ext_src ext_u (.ref_clk, .run(ext_run), .ext_clock_pin);
  // ====
  // tasks
  task automatic chk(input string w, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic acc(input logic r, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= r;
    avs_write <= !r;
    // waitrequest is looked at mid-cycle, where it has settled
    @(negedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20) n_errors++;
    @(posedge ref_clk);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rc(input string w, input logic [5:0] a, input logic [31:0] e);
    acc(1'b1, a, 32'h0000_0000);
    chk(w, rdat, e);
  endtask
  // halt drops for n+4 clocks; the tail lets the edge detector catch up
  task automatic run(input int n, input logic x);
    halt_mode <= 1'b0;
    ext_run <= x;
    repeat (n) @(posedge ref_clk);
    ext_run <= 1'b0;
    repeat (4) @(posedge ref_clk);
    halt_mode <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  function automatic logic [15:0] exp_cnt(input int t);
    return 16'hFFFC + 16'(t);
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====
  // tests
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    conclude;
  end
  initial begin
    int r;
    logic [15:0] e;
    logic [31:0] lo;
    frtc_ctrl2_t c2;
    r = $urandom(32'hed86_b3fb);
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rc("unmapped", 6'h24, 32'h0000_0000);
    rc("reset hi", `FRTC_OFF_CNT_HI, 32'h0000_00ff);
    rc("reset lo", `FRTC_OFF_CNT_LO, 32'h0000_00fc);
    acc(1'b0, `FRTC_OFF_CTRL1, 32'h0000_0001);
    acc(1'b0, `FRTC_OFF_IRQ_MASK, 32'h0000_0001);
    // 0..2 prescaled, 3 rising external, 4 falling external
    for (int i = 0; i < 5; i++) begin
      r = (i < 3) ? $urandom_range(19, 4) : 2 * $urandom_range(9, 4) + 1;
      c2.ext_edge_select = (i == 3);
      c2.clock_select_field = frtc_clk_src_t'(i < 3 ? i : 3);
      global_irq_mask <= (i == 1);
      acc(1'b0, `FRTC_OFF_CTRL2, 32'(c2));
      acc(1'b0, i[0] ? `FRTC_OFF_ALT_LO : `FRTC_OFF_CNT_LO, 32'h0);
      rc("hi latch", `FRTC_OFF_CNT_HI, 32'h0000_00ff);
      if (i < 3)
        run(8 * r - 4, 1'b0);
      else
        run(4 * r, 1'b1);
      e = exp_cnt((i < 3) ? (8 * r) >> (i + 1) : (r + 1) / 2);
      lo = {24'h00_0000, e[7:0]};
      rc("lo latched", `FRTC_OFF_CNT_LO, 32'h0000_00fc);
      rc("lo live", `FRTC_OFF_CNT_LO, lo);
      rc("alt hi", `FRTC_OFF_ALT_HI, {24'h00_0000, e[15:8]});
      rc("alt lo", `FRTC_OFF_ALT_LO, lo);
      rc("flag set", `FRTC_OFF_STATUS, 32'h0000_0001);
      rc("alt no clear", `FRTC_OFF_ALT_LO, lo);
      rc("flag kept", `FRTC_OFF_STATUS, 32'h0000_0001);
      rc("lo clear", `FRTC_OFF_CNT_LO, lo);
      rc("flag clear", `FRTC_OFF_STATUS, 32'h0000_0000);
      chk("irq", irq, i != 1);
      global_irq_mask <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("irq pending", irq, 1'b1);
      acc(1'b0, `FRTC_OFF_IRQ_STAT, 32'h0000_0001);
      repeat (2) @(posedge ref_clk);
      chk("irq cleared", irq, 1'b0);
      $display("test %0d done", i);
    end
    // mid-run reset: count must restart from the reload value
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rc("rst hi", `FRTC_OFF_CNT_HI, 32'h0000_00ff);
    rc("rst lo", `FRTC_OFF_ALT_LO, 32'h0000_00fc);
    rc("rst flag", `FRTC_OFF_STATUS, 32'h0000_0000);
    $display("test reset done");
    conclude;
  end
endmodule
`default_nettype wire
